// >>> rtl/uil_line_ctrl.sv
// Interrupt identification and line framing control with an AXI4-Lite slave.
//
// Register access over AXI4-Lite was chosen for this implementation.
`include "uil_defs.svh"
`timescale 1ns/10ps
`default_nettype none
module uil_line_ctrl #(
  parameter int unsigned AW       = 6,
  parameter int unsigned TO_CHARS = `UIL_TO_CHARS
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [AW-1:0]     s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output uil_pkg::uil_resp_t     s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [AW-1:0]     s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output uil_pkg::uil_resp_t     s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic              fifo_mode,
  input  wire logic              rx_nonempty,
  input  wire logic              rx_activity,
  input  wire logic              bit_tick,
  input  wire logic              ls_event,
  input  wire logic              rda_level,
  input  wire logic              thre_event,
  input  wire logic              ms_event,
  input  wire logic              rx_strobe,
  input  wire logic [7:0]        rx_data,
  input  wire logic              rx_par,
  input  wire logic              rx_stop,
  input  wire logic [7:0]        tx_char,
  input  wire logic              tx_serial,
  output logic                   txd,
  output logic                   tx_parity_bit,
  output logic [3:0]             data_bits,
  output logic                   parity_enable,
  output logic [2:0]             stop_halves,
  output logic [15:0]            divisor,
  output logic                   rx_parity_err,
  output logic                   rx_framing_err,
  output logic                   rx_buf_read,
  output logic                   thr_write,
  output logic                   lsr_read,
  output logic                   msr_read,
  output logic                   irq
);
  import uil_pkg::*;

  initial begin
    if (AW < 6 || TO_CHARS < 1 || TO_CHARS > 16) begin
      $error("uil_line_ctrl: AW must be at least 6 and TO_CHARS within 1 to 16.");
    end
  end

  function automatic logic is_mapped(input logic [3:0] i);
    is_mapped = (i <= 4'h3) || (i == 4'h5) || (i == 4'h6) || (i == 4'h8) || (i == 4'h9);
  endfunction : is_mapped

  // Used on transmit and receive so both ends agree on the same bit.
  function automatic logic par_bit(input logic [7:0] d, input logic [7:0] l);
    logic [7:0] m;
    m = d & ~(8'he0 << l[1:0]);
    if (l[`UIL_STICK]) begin
      par_bit = ~l[`UIL_EVEN];
    end else begin
      par_bit = l[`UIL_EVEN] ? ^m : ~^m;
    end
  endfunction : par_bit

  // Bus state.
  logic        aw_got_r, aw_got_nxt, w_got_r, w_got_nxt;
  logic [3:0]  waddr_r, waddr_nxt, raddr_r, raddr_nxt;
  logic [31:0] wdata_r, wdata_nxt, rdata_r, rdata_nxt;
  logic        wstb_r, wstb_nxt, bvalid_r, bvalid_nxt;
  uil_resp_t   bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  uil_rd_t     rd_st_r, rd_st_nxt;
  // Line state.
  logic [7:0]  lfc_r, lfc_nxt, dll_r, dll_nxt, dlm_r, dlm_nxt;
  logic        ls_pend_r, ls_pend_nxt, to_pend_r, to_pend_nxt;
  logic        thre_pend_r, thre_pend_nxt, ms_pend_r, ms_pend_nxt;
  logic [7:0]  to_cnt_r, to_cnt_nxt;
  logic [2:0]  isr_r, isr_nxt, imr_r, imr_nxt;
  logic        txd_r, txd_nxt, tx_par_r, tx_par_nxt, pe_r, pe_nxt, fe_r, fe_nxt;
  logic [3:0]  dbits_r, dbits_nxt;
  logic [2:0]  stop_r, stop_nxt;
  logic        pen_r, pen_nxt, irq_r, irq_nxt;
  logic        rbr_rd_r, rbr_rd_nxt, thr_wr_r, thr_wr_nxt;
  logic        lsr_rd_r, lsr_rd_nxt, msr_rd_r, msr_rd_nxt;

  logic        dwin, wr_exec, rd_done, isid_rd, to_set;
  logic [3:0]  live_code;
  logic [7:0]  frame, to_lim;

  assign dwin          = lfc_r[`UIL_DWIN];
  assign s_axi_awready = !aw_got_r && !bvalid_r;
  assign s_axi_wready  = !w_got_r && !bvalid_r;
  assign s_axi_arready = (rd_st_r == UIL_RD_IDLE);
  assign wr_exec       = aw_got_r && w_got_r;
  assign rd_done       = (rd_st_r == UIL_RD_RESP) && s_axi_rready;
  assign isid_rd       = rd_done && (raddr_r == `UIL_IDX_ISID);

  always_comb begin
    if (ls_pend_r) begin
      live_code = `UIL_CODE_LS;
    end else if (rda_level) begin
      live_code = `UIL_CODE_RDA;
    end else if (to_pend_r && fifo_mode) begin
      live_code = `UIL_CODE_TO;
    end else if (thre_pend_r) begin
      live_code = `UIL_CODE_THRE;
    end else if (ms_pend_r) begin
      live_code = `UIL_CODE_MS;
    end else begin
      live_code = `UIL_CODE_NONE;
    end
  end

  always_comb begin
    aw_got_nxt = aw_got_r;
    w_got_nxt  = w_got_r;
    waddr_nxt  = waddr_r;
    wdata_nxt  = wdata_r;
    wstb_nxt   = wstb_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt  = bresp_r;
    rd_st_nxt  = rd_st_r;
    raddr_nxt  = raddr_r;
    rdata_nxt  = rdata_r;
    rresp_nxt  = rresp_r;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_got_nxt = 1'b1;
      waddr_nxt  = s_axi_awaddr[5:2];
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_got_nxt = 1'b1;
      wdata_nxt = s_axi_wdata;
      wstb_nxt  = s_axi_wstrb[0];
    end
    if (wr_exec) begin
      aw_got_nxt = 1'b0;
      w_got_nxt  = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt  = is_mapped(waddr_r) ? UIL_OKAY : UIL_SLVERR;
    end else if (bvalid_r && s_axi_bready) begin
      bvalid_nxt = 1'b0;
    end
    case (rd_st_r)
      UIL_RD_IDLE: begin
        if (s_axi_arvalid) begin
          rd_st_nxt = UIL_RD_RESP;
          raddr_nxt = s_axi_araddr[5:2];
          rresp_nxt = is_mapped(s_axi_araddr[5:2]) ? UIL_OKAY : UIL_SLVERR;
          // The snapshot taken here is what the reader sees until completion.
          case (s_axi_araddr[5:2])
            `UIL_IDX_DLL: rdata_nxt = {24'h0, dwin ? dll_r : 8'h00};
            `UIL_IDX_DLM: rdata_nxt = {24'h0, dwin ? dlm_r : 8'h00};
            `UIL_IDX_ISID: rdata_nxt = {24'h0, {2{fifo_mode}}, 2'b00, live_code};
            `UIL_IDX_LFC: rdata_nxt = {24'h0, lfc_r};
            `UIL_IDX_ISR: rdata_nxt = {29'h0, isr_r};
            `UIL_IDX_IMR: rdata_nxt = {29'h0, imr_r};
            default:      rdata_nxt = 32'h0;
          endcase
        end
      end
      UIL_RD_RESP: begin
        if (s_axi_rready) begin
          rd_st_nxt = UIL_RD_IDLE;
        end
      end
      default: rd_st_nxt = UIL_RD_IDLE;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_r <= 1'b0;
      w_got_r  <= 1'b0;
      waddr_r  <= 4'h0;
      wdata_r  <= 32'h0;
      wstb_r   <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r  <= UIL_OKAY;
      rd_st_r  <= UIL_RD_IDLE;
      raddr_r  <= 4'h0;
      rdata_r  <= 32'h0;
      rresp_r  <= UIL_OKAY;
    end else begin
      aw_got_r <= aw_got_nxt;
      w_got_r  <= w_got_nxt;
      waddr_r  <= waddr_nxt;
      wdata_r  <= wdata_nxt;
      wstb_r   <= wstb_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r  <= bresp_nxt;
      rd_st_r  <= rd_st_nxt;
      raddr_r  <= raddr_nxt;
      rdata_r  <= rdata_nxt;
      rresp_r  <= rresp_nxt;
    end
  end

  always_comb begin
    frame  = 8'd1 + {4'h0, dbits_r} + {7'h0, pen_r} + (lfc_r[`UIL_STOP] ? 8'd2 : 8'd1);
    to_lim = 8'(frame * TO_CHARS);
    to_set = fifo_mode && rx_nonempty && (to_cnt_r >= to_lim);
    lfc_nxt = lfc_r;
    dll_nxt = dll_r;
    dlm_nxt = dlm_r;
    imr_nxt = imr_r;
    isr_nxt = isr_r;
    thr_wr_nxt = wr_exec && wstb_r && (waddr_r == `UIL_IDX_DLL) && !dwin;
    if (wr_exec && wstb_r) begin
      case (waddr_r)
        `UIL_IDX_DLL: if (dwin) dll_nxt = wdata_r[7:0];
        `UIL_IDX_DLM: if (dwin) dlm_nxt = wdata_r[7:0];
        `UIL_IDX_LFC: lfc_nxt = wdata_r[7:0];
        `UIL_IDX_ISR: isr_nxt = isr_r & ~wdata_r[2:0];
        `UIL_IDX_IMR: imr_nxt = wdata_r[2:0];
        default:      imr_nxt = imr_r;
      endcase
    end
    rbr_rd_nxt = rd_done && (raddr_r == `UIL_IDX_DLL) && !dwin;
    lsr_rd_nxt = rd_done && (raddr_r == `UIL_IDX_LSR);
    msr_rd_nxt = rd_done && (raddr_r == `UIL_IDX_MSR);
    // Sources set before clears are applied, so a simultaneous event survives.
    ls_pend_nxt   = ls_event || (ls_pend_r && !lsr_rd_nxt);
    ms_pend_nxt   = ms_event || (ms_pend_r && !msr_rd_nxt);
    to_pend_nxt   = to_set || (to_pend_r && !rbr_rd_nxt);
    thre_pend_nxt = thre_event || (thre_pend_r && !thr_wr_nxt
                    && !(isid_rd && rdata_r[3:0] == `UIL_CODE_THRE));
    if (!rx_nonempty || rx_activity) begin
      to_cnt_nxt = 8'h00;
    end else if (bit_tick && to_cnt_r != 8'hff) begin
      to_cnt_nxt = to_cnt_r + 8'h01;
    end else begin
      to_cnt_nxt = to_cnt_r;
    end
    pe_nxt = rx_strobe && lfc_r[`UIL_PEN] && (rx_par != par_bit(rx_data, lfc_r));
    fe_nxt = rx_strobe && !rx_stop;
    isr_nxt = isr_nxt | {fe_nxt, pe_nxt, to_set && !to_pend_r};
    irq_nxt = |(isr_nxt & imr_nxt);
    txd_nxt = lfc_r[`UIL_BRK] ? 1'b0 : tx_serial;
    tx_par_nxt = par_bit(tx_char, lfc_r);
    pen_nxt = lfc_r[`UIL_PEN];
    dbits_nxt = 4'd5 + {2'b00, lfc_r[1:0]};
    stop_nxt = !lfc_r[`UIL_STOP] ? 3'd2 : (lfc_r[1:0] == 2'b00 ? 3'd3 : 3'd4);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lfc_r <= `UIL_LFC_RST;
      dll_r <= `UIL_DIV_RST;
      dlm_r <= `UIL_DIV_RST;
      imr_r <= `UIL_IMR_RST;
      isr_r <= 3'h0;
      ls_pend_r <= 1'b0;
      ms_pend_r <= 1'b0;
      to_pend_r <= 1'b0;
      thre_pend_r <= 1'b0;
      to_cnt_r <= 8'h00;
      pe_r <= 1'b0;
      fe_r <= 1'b0;
      irq_r <= 1'b0;
      txd_r <= 1'b1;
      tx_par_r <= 1'b0;
      pen_r <= 1'b0;
      dbits_r <= 4'd5;
      stop_r <= 3'd2;
      rbr_rd_r <= 1'b0;
      thr_wr_r <= 1'b0;
      lsr_rd_r <= 1'b0;
      msr_rd_r <= 1'b0;
    end else begin
      lfc_r <= lfc_nxt;
      dll_r <= dll_nxt;
      dlm_r <= dlm_nxt;
      imr_r <= imr_nxt;
      isr_r <= isr_nxt;
      ls_pend_r <= ls_pend_nxt;
      ms_pend_r <= ms_pend_nxt;
      to_pend_r <= to_pend_nxt;
      thre_pend_r <= thre_pend_nxt;
      to_cnt_r <= to_cnt_nxt;
      pe_r <= pe_nxt;
      fe_r <= fe_nxt;
      irq_r <= irq_nxt;
      txd_r <= txd_nxt;
      tx_par_r <= tx_par_nxt;
      pen_r <= pen_nxt;
      dbits_r <= dbits_nxt;
      stop_r <= stop_nxt;
      rbr_rd_r <= rbr_rd_nxt;
      thr_wr_r <= thr_wr_nxt;
      lsr_rd_r <= lsr_rd_nxt;
      msr_rd_r <= msr_rd_nxt;
    end
  end

  assign s_axi_bvalid   = bvalid_r;
  assign s_axi_bresp    = bresp_r;
  assign s_axi_rvalid   = (rd_st_r == UIL_RD_RESP);
  assign s_axi_rdata    = rdata_r;
  assign s_axi_rresp    = rresp_r;
  assign txd            = txd_r;
  assign tx_parity_bit  = tx_par_r;
  assign data_bits      = dbits_r;
  assign parity_enable  = pen_r;
  assign stop_halves    = stop_r;
  assign divisor        = {dlm_r, dll_r};
  assign rx_parity_err  = pe_r;
  assign rx_framing_err = fe_r;
  assign rx_buf_read    = rbr_rd_r;
  assign thr_write      = thr_wr_r;
  assign lsr_read       = lsr_rd_r;
  assign msr_read       = msr_rd_r;
  assign irq            = irq_r;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  AST_NONE_FLAG: assert property ((live_code == `UIL_CODE_NONE) ==
    !(ls_pend_r || rda_level || (to_pend_r && fifo_mode) || thre_pend_r || ms_pend_r))
    else $error("Pending flag disagrees with sources.");
  AST_LSHI: assert property (ls_pend_r |-> live_code == `UIL_CODE_LS)
    else $error("Line status is not reported first.");
  AST_TORISE: assert property ($rose(to_pend_r) |-> $past(rx_nonempty) && $past(fifo_mode))
    else $error("Timeout rose without stored characters.");
  AST_THRCLR: assert property (thr_wr_nxt && !thre_event |=> !thre_pend_r)
    else $error("Holding write did not clear transmit empty.");
  AST_DLL: assert property (wr_exec && wstb_r && waddr_r == `UIL_IDX_DLL && dwin
    |=> dll_r == $past(wdata_r[7:0])) else $error("Divisor latch not written.");
  AST_BRK: assert property (lfc_r[`UIL_BRK] |=> !txd)
    else $error("Break did not hold the line low.");
  AST_SPACE: assert property (lfc_r[5:3] == 3'b111 |=> !tx_parity_bit)
    else $error("Space parity not sent as 0.");
  AST_MARK: assert property (lfc_r[5:3] == 3'b101 |=> tx_parity_bit)
    else $error("Mark parity not sent as 1.");
  AST_STOP: assert property (!lfc_r[`UIL_STOP] |=> stop_halves == 3'd2)
    else $error("Stop count wrong for one stop bit.");
  AST_FREEZE: assert property (s_axi_rvalid && !s_axi_rready |=> $stable(s_axi_rdata))
    else $error("Read data changed during the access.");
  AST_BIT3: assert property (!fifo_mode |-> !live_code[3])
    else $error("Bit 3 set outside FIFO mode.");
endmodule : uil_line_ctrl
`default_nettype wire

// >>> common/uil_defs.svh
// Register indices, field positions, reset values and counts of the line control block.
`ifndef UIL_DEFS_SVH
`define UIL_DEFS_SVH
`define UIL_IDX_DLL  4'h0
`define UIL_IDX_DLM  4'h1
`define UIL_IDX_ISID 4'h2
`define UIL_IDX_LFC  4'h3
`define UIL_IDX_LSR  4'h5
`define UIL_IDX_MSR  4'h6
`define UIL_IDX_ISR  4'h8
`define UIL_IDX_IMR  4'h9
`define UIL_LFC_RST  8'h00
`define UIL_IMR_RST  3'h0
`define UIL_DIV_RST  8'h00
`define UIL_DWIN     7
`define UIL_BRK      6
`define UIL_STICK    5
`define UIL_EVEN     4
`define UIL_PEN      3
`define UIL_STOP     2
`define UIL_CODE_NONE 4'h1
`define UIL_CODE_LS   4'h6
`define UIL_CODE_RDA  4'h4
`define UIL_CODE_TO   4'hc
`define UIL_CODE_THRE 4'h2
`define UIL_CODE_MS   4'h0
`define UIL_TO_CHARS 4
`endif

// >>> common/uil_pkg.sv
// Types shared by the line control block.
package uil_pkg;
  typedef enum logic [1:0] {
    UIL_OKAY   = 2'b00,
    UIL_SLVERR = 2'b10
  } uil_resp_t;
  typedef enum logic {
    UIL_RD_IDLE = 1'b0,
    UIL_RD_RESP = 1'b1
  } uil_rd_t;
endpackage : uil_pkg

// >>> sim/uil_line_model.sv
// Behavioural far side: bit-time ticks and received characters for the line control block.
`timescale 1ns/10ps
`default_nettype none
module uil_line_model (
  input  wire logic       aclk,
  output logic            bit_tick,
  output logic            rx_strobe,
  output logic [7:0]      rx_data,
  output logic            rx_par,
  output logic            rx_stop,
  input  wire logic       rx_parity_err,
  input  wire logic       rx_framing_err
);
  initial begin
    bit_tick  = 1'b0;
    rx_strobe = 1'b0;
    rx_data   = 8'ha5;
    rx_par    = 1'b0;
    rx_stop   = 1'b1;
  end
  // One tick per bit time, spaced so that each is seen as a single pulse.
  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge aclk);
      bit_tick <= 1'b1;
      @(posedge aclk);
      bit_tick <= 1'b0;
    end
  endtask : ticks
  // Delivers one character with its parity bit and only its first stop bit.
  task automatic send(input logic [7:0] d, input logic p, input logic s,
                      output logic pe, output logic fe);
    @(posedge aclk);
    rx_strobe <= 1'b1;
    rx_data   <= d;
    rx_par    <= p;
    rx_stop   <= s;
    @(posedge aclk);
    rx_strobe <= 1'b0;
    // Released lines show the inverse so that a stale sample cannot pass.
    rx_data   <= ~d;
    rx_par    <= ~p;
    rx_stop   <= ~s;
    @(posedge aclk);
    pe = rx_parity_err;
    fe = rx_framing_err;
  endtask : send
endmodule : uil_line_model
`default_nettype wire

// >>> sim/tb.sv
// Self-checking bench for the line control block over AXI4-Lite.
`include "uil_defs.svh"
`timescale 1ns/10ps
`default_nettype none
module tb;
  import uil_pkg::*;
  logic        aclk, aresetn, fifo_mode, rx_nonempty, rx_activity, bit_tick, rda_level;
  logic [5:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0]  s_axi_wstrb, data_bits;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  uil_resp_t   s_axi_bresp, s_axi_rresp, rs;
  logic        rx_strobe, rx_par, rx_stop, tx_serial, txd, tx_parity_bit, parity_enable;
  logic        rx_parity_err, rx_framing_err, rx_buf_read, thr_write, lsr_read, msr_read;
  logic        irq, pe, fe;
  logic [2:0]  ev, stop_halves;
  logic [7:0]  rx_data, tx_char;
  logic [15:0] divisor;
  int          failures = 0, checked = 0, cycles = 0;
  localparam logic [7:0] PMODE [4] = '{8'h0f, 8'h1f, 8'h2f, 8'h3f};
  localparam logic       PEXP  [4] = '{1'b0, 1'b1, 1'b1, 1'b0};
  uil_line_ctrl #(.AW(6), .TO_CHARS(2)) DUT (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .fifo_mode, .rx_nonempty, .rx_activity, .bit_tick,
    .ls_event(ev[0]), .rda_level, .thre_event(ev[1]), .ms_event(ev[2]), .rx_strobe,
    .rx_data, .rx_par, .rx_stop, .tx_char, .tx_serial, .txd, .tx_parity_bit, .data_bits,
    .parity_enable, .stop_halves, .divisor, .rx_parity_err, .rx_framing_err, .rx_buf_read,
    .thr_write, .lsr_read, .msr_read, .irq);
  uil_line_model PTR (.aclk, .bit_tick, .rx_strobe, .rx_data, .rx_par, .rx_stop,
    .rx_parity_err, .rx_framing_err);
  initial aclk = 1'b0;
  always #2 aclk = ~aclk;
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : report_and_stop
  // A hung handshake ends here rather than running forever.
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 8000) begin
      failures++;
      report_and_stop();
    end
  end
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic idle(input int n);
    repeat (n) @(posedge aclk);
  endtask : idle
  task automatic axw(input logic [3:0] idx, input logic [31:0] d);
    logic done;
    done = 1'b0;
    @(posedge aclk);
    s_axi_awaddr  <= {idx, 2'b00};
    s_axi_awvalid <= 1'b1;
    s_axi_wdata   <= d;
    s_axi_wstrb   <= 4'hf;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    while (!done) begin
      @(posedge aclk);
      if (s_axi_awvalid === 1'b1 && s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid === 1'b1 && s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) begin
        rs = s_axi_bresp;
        s_axi_bready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask : axw
  task automatic axr(input logic [3:0] idx, output logic [31:0] d);
    logic done;
    done = 1'b0;
    @(posedge aclk);
    s_axi_araddr  <= {idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    while (!done) begin
      @(posedge aclk);
      if (s_axi_arvalid === 1'b1 && s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) begin
        d = s_axi_rdata;
        rs = s_axi_rresp;
        s_axi_rready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask : axr
  task automatic isi_chk(input logic [7:0] exp);
    axr(`UIL_IDX_ISID, rd);
    chk("interrupt_source_id", rd, {24'h0, exp});
    idle(2);
  endtask : isi_chk
  task automatic fire(input logic [2:0] e);
    @(posedge aclk);
    ev <= e;
    @(posedge aclk);
    ev <= 3'h0;
  endtask : fire
  initial begin
    {aresetn, fifo_mode, rx_nonempty, rx_activity, rda_level, ev} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    tx_serial = 1'b1;
    tx_char = 8'h0b;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    isi_chk(`UIL_CODE_NONE);
    axr(`UIL_IDX_LFC, rd);
    chk("line_framing_control", rd, {24'h0, `UIL_LFC_RST});
    chk("txd", txd, 1);
    chk("stop_halves", stop_halves, 2);
    axr(4'hf, rd);
    chk("unmapped rresp", rs, UIL_SLVERR);
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      axw(`UIL_IDX_LFC, 32'h04 + 32'(i));
      chk("write bresp", rs, UIL_OKAY);
      idle(2);
      chk("data_bits", data_bits, 5 + i);
      chk("stop_halves", stop_halves, (i == 0) ? 3 : 4);
    end
    $display("test framing done");
    for (int i = 0; i < 4; i++) begin
      axw(`UIL_IDX_LFC, {24'h0, PMODE[i]});
      idle(2);
      chk("parity_enable", parity_enable, 1);
      chk("tx_parity_bit", tx_parity_bit, PEXP[i]);
      PTR.send(8'h0b, PEXP[i], 1'b1, pe, fe);
      chk("rx_parity_err", pe, 0);
      chk("rx_framing_err", fe, 0);
      PTR.send(8'h0b, ~PEXP[i], 1'b0, pe, fe);
      chk("rx_parity_err", pe, 1);
      chk("rx_framing_err", fe, 1);
    end
    $display("test parity done");
    fire(3'b010);
    isi_chk(`UIL_CODE_THRE);
    isi_chk(`UIL_CODE_NONE);
    fire(3'b011);
    isi_chk(`UIL_CODE_LS);
    axr(`UIL_IDX_LSR, rd);
    idle(1);
    chk("lsr_read", lsr_read, 1);
    idle(1);
    isi_chk(`UIL_CODE_THRE);
    fire(3'b010);
    axw(`UIL_IDX_DLL, 32'h0);
    chk("thr_write", thr_write, 1);
    idle(2);
    isi_chk(`UIL_CODE_NONE);
    rda_level <= 1'b1;
    idle(2);
    isi_chk(`UIL_CODE_RDA);
    rda_level <= 1'b0;
    fire(3'b100);
    isi_chk(`UIL_CODE_MS);
    axr(`UIL_IDX_MSR, rd);
    idle(1);
    chk("msr_read", msr_read, 1);
    idle(1);
    isi_chk(`UIL_CODE_NONE);
    $display("test identification done");
    axw(`UIL_IDX_LFC, 32'h80);
    axw(`UIL_IDX_DLL, 32'h34);
    axw(`UIL_IDX_DLM, 32'h12);
    idle(2);
    chk("divisor", divisor, 16'h1234);
    axr(`UIL_IDX_DLL, rd);
    chk("divisor low", rd, 32'h34);
    axw(`UIL_IDX_LFC, 32'h00);
    axw(`UIL_IDX_DLL, 32'h55);
    idle(2);
    chk("divisor", divisor, 16'h1234);
    $display("test divisor done");
    axw(`UIL_IDX_LFC, 32'h40);
    idle(6);
    chk("txd", txd, 0);
    axw(`UIL_IDX_LFC, 32'h00);
    idle(2);
    chk("txd", txd, 1);
    tx_serial <= 1'b0;
    idle(2);
    chk("txd", txd, 0);
    tx_serial <= 1'b1;
    $display("test break done");
    axw(`UIL_IDX_ISR, 32'h7);
    fifo_mode <= 1'b1;
    rx_nonempty <= 1'b1;
    PTR.ticks(10);
    @(posedge aclk) rx_activity <= 1'b1;
    @(posedge aclk) rx_activity <= 1'b0;
    PTR.ticks(13);
    isi_chk(8'hc1);
    PTR.ticks(1);
    isi_chk(8'hcc);
    axr(`UIL_IDX_ISR, rd);
    chk("interrupt status", rd, 32'h1);
    chk("irq", irq, 0);
    axw(`UIL_IDX_IMR, 32'h1);
    idle(2);
    chk("irq", irq, 1);
    rx_nonempty <= 1'b0;
    axr(`UIL_IDX_DLL, rd);
    idle(1);
    chk("rx_buf_read", rx_buf_read, 1);
    idle(1);
    isi_chk(8'hc1);
    axw(`UIL_IDX_ISR, 32'h1);
    idle(2);
    chk("irq", irq, 0);
    $display("test timeout done");
    report_and_stop();
  end
endmodule : tb
`default_nettype wire
